// ==== rtl/agtc_defs.svh ====
/*
  agtc_defs.svh - offsets, field positions, reset value, baseline times and
  decay ceilings of the record-path agc time-constant register bank.
  assumes: included by bare name from the bank itself.
*/
`ifndef AGTC_DEFS_SVH
`define AGTC_DEFS_SVH

// ==========================================================================
// register offsets, page 0
`define AGTC_OFF_LEFT_DECAY 7'h68
`define AGTC_OFF_RIGHT_ATTACK 7'h69
`define AGTC_OFF_RIGHT_DECAY 7'h6a

// ==========================================================================
// field positions and reset value
`define AGTC_BIT_SRC_SEL 7
`define AGTC_FLD_BASE_HI 6
`define AGTC_FLD_BASE_LO 5
`define AGTC_FLD_MULT_HI 4
`define AGTC_FLD_MULT_LO 2
`define AGTC_REG_RESET 8'h00

// ==========================================================================
// baseline times in ms
`define AGTC_ATK_MS_0 16'h0007
`define AGTC_ATK_MS_1 16'h0008
`define AGTC_ATK_MS_2 16'h000a
`define AGTC_ATK_MS_3 16'h000b
`define AGTC_DEC_MS_0 16'h0032
`define AGTC_DEC_MS_1 16'h0096
`define AGTC_DEC_MS_2 16'h00fa
`define AGTC_DEC_MS_3 16'h015e

// ==========================================================================
// decay ceilings in ms, keyed by twice the decimation ratio
`define AGTC_CAP_R1_MS 16'h0fa0
`define AGTC_CAP_R1P5_MS 16'h15e0
`define AGTC_CAP_R2_MS 16'h1f40
`define AGTC_CAP_R2P5_MS 16'h2580
`define AGTC_CAP_R3_MS 16'h2bc0
`define AGTC_CAP_R4_MS 16'h3e80
`define AGTC_CAP_R5_MS 16'h4b00
`define AGTC_CAP_R5P5_MS 16'h5780

`endif

// ==== rtl/agtc_pkg.sv ====
/*
  agtc_pkg.sv - types shared by the agc time-constant register bank.
  assumes: nothing; the constants live in the defs header.
*/
`default_nettype none

// ==========================================================================
// types
package agtc_pkg;
  // one time-constant register as stored
  typedef struct packed {
    logic src_new;     // 1: use this register, 0: legacy source
    logic [1:0] base;  // baseline time code
    logic [2:0] mult;  // power-of-two factor code
    logic [1:0] rsvd;  // reserved, kept as written
  } agtc_tc_t;
  // effective time handed to the agc core
  typedef struct packed {
    logic src_new;     // programmable source in use
    logic [15:0] ms;   // effective time in ms
  } agtc_eff_t;
endpackage

`default_nettype wire

// ==== rtl/agtc_regs.sv ====
/*
  agtc_regs.sv - left decay, right attack and right decay time-constant
  registers of the record-path agc, with the effective-time computation.
  assumes: the control-bus decoder (spi or i2c) presents one-cycle
  page-0 write and read strobes on sys_clk; legacy times from the older
  agc registers arrive already decoded in ms; the decimation ratio
  arrives as twice its value (2 for 1, 3 for 1.5 ... 12 for 6).
*/
// Operation
// - left decay source: legacy or this register
// - left decay baseline 50/150/250/350 ms
// - decay baseline times power-of-two factor up to 128
// - right attack baseline times power-of-two factor
// - right attack source: legacy or this register
// - right attack baseline 7/8/10/11 ms
// - right decay source: legacy or this register
// - right decay baseline 50/150/250/350 ms
// - decay ceiling 4/5.6/8/9.6 s by ratio
// - higher ratios cap decay at 11.2-22.4 s
`timescale 1ns/1ps
`default_nettype none
`include "agtc_defs.svh"

module agtc_regs #(
  parameter int NUM_TC = 3  // time-constant registers: left decay, right attack, right decay
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port from the control-bus decoder
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_hit,
  // legacy times and decimation ratio
  input wire logic [15:0] legacy_left_decay_ms,
  input wire logic [15:0] legacy_right_attack_ms,
  input wire logic [15:0] legacy_right_decay_ms,
  input wire logic [3:0] adc_decimation_ratio,
  // effective times to the agc core
  output agtc_pkg::agtc_eff_t left_decay_eff,
  output agtc_pkg::agtc_eff_t right_attack_eff,
  output agtc_pkg::agtc_eff_t right_decay_eff
);

  // ==========================================================================
  // storage and helpers

  localparam int CH_LDEC = 0;  // left decay
  localparam int CH_RATK = 1;  // right attack
  localparam int CH_RDEC = 2;  // right decay

  agtc_pkg::agtc_tc_t tc_r [NUM_TC];     // stored registers
  agtc_pkg::agtc_tc_t tc_nxt [NUM_TC];   // next register values
  agtc_pkg::agtc_eff_t eff_r [NUM_TC];   // registered effective times
  agtc_pkg::agtc_eff_t eff_nxt [NUM_TC]; // next effective times
  logic [15:0] legacy_ms [NUM_TC];       // legacy time per channel
  logic [NUM_TC-1:0] sel_hit;            // address matches channel
  logic [7:0] rdata_r;                   // read data register
  logic [7:0] rdata_nxt;
  logic rvalid_r;                        // read answer strobe
  logic rvalid_nxt;
  logic [15:0] cap_ms;                   // decay ceiling for the ratio

  assign legacy_ms[CH_LDEC] = legacy_left_decay_ms;
  assign legacy_ms[CH_RATK] = legacy_right_attack_ms;
  assign legacy_ms[CH_RDEC] = legacy_right_decay_ms;

  // baseline decode; attack and decay share a code but not a table
  function automatic logic [15:0] base_ms(input logic is_atk, input logic [1:0] code);
    logic [15:0] t;
    t = 16'h0000;
    if (is_atk) begin
      case (code)
        2'h0: t = `AGTC_ATK_MS_0;
        2'h1: t = `AGTC_ATK_MS_1;
        2'h2: t = `AGTC_ATK_MS_2;
        default: t = `AGTC_ATK_MS_3;
      endcase
    end else begin
      case (code)
        2'h0: t = `AGTC_DEC_MS_0;
        2'h1: t = `AGTC_DEC_MS_1;
        2'h2: t = `AGTC_DEC_MS_2;
        default: t = `AGTC_DEC_MS_3;
      endcase
    end
    return t;
  endfunction

  // ==========================================================================
  // decay ceiling from the decimation ratio

  // out-of-range ratio codes fall back to the tightest ceiling, so a bad
  // setting can only shorten decay, never stretch it past any legal limit
  always_comb begin
    case (adc_decimation_ratio)
      4'h2: cap_ms = `AGTC_CAP_R1_MS;
      4'h3: cap_ms = `AGTC_CAP_R1P5_MS;
      4'h4: cap_ms = `AGTC_CAP_R2_MS;
      4'h5: cap_ms = `AGTC_CAP_R2P5_MS;
      4'h6, 4'h7: cap_ms = `AGTC_CAP_R3_MS;
      4'h8, 4'h9: cap_ms = `AGTC_CAP_R4_MS;
      4'ha: cap_ms = `AGTC_CAP_R5_MS;
      4'hb, 4'hc: cap_ms = `AGTC_CAP_R5P5_MS;
      default: cap_ms = `AGTC_CAP_R1_MS;
    endcase
  end

  // ==========================================================================
  // per-channel register and effective time

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TC; gi++) begin : g_ch
      logic [15:0] raw_ms;  // selected time before the ceiling
      // offsets are consecutive from the left decay register
      assign sel_hit[gi] = (reg_addr == (`AGTC_OFF_LEFT_DECAY + 7'(gi)));

      // write path: all eight bits stored, reserved bits included; the
      // low two are expected to be written as zero by software
      always_comb begin
        tc_nxt[gi] = tc_r[gi];
        if (reg_wr && sel_hit[gi]) begin
          tc_nxt[gi] = agtc_pkg::agtc_tc_t'(reg_wdata);
        end
      end

      // effective time: baseline shifted by the factor code, or legacy
      always_comb begin
        if (tc_r[gi].src_new) begin
          // largest product is 350 ms x 128, still inside 16 bits
          raw_ms = base_ms(gi == CH_RATK, tc_r[gi].base) << tc_r[gi].mult;
        end else begin
          raw_ms = legacy_ms[gi];
        end
        eff_nxt[gi].src_new = tc_r[gi].src_new;
        // only decay is limited; attack passes through unchanged
        if (gi != CH_RATK && raw_ms > cap_ms) begin
          eff_nxt[gi].ms = cap_ms;
        end else begin
          eff_nxt[gi].ms = raw_ms;
        end
      end

      // register stage
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          tc_r[gi] <= agtc_pkg::agtc_tc_t'(`AGTC_REG_RESET);
          eff_r[gi] <= '0;
        end else begin
          tc_r[gi] <= tc_nxt[gi];
          eff_r[gi] <= eff_nxt[gi];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // read path

  // unmapped addresses answer zero; hit tells the decoder the address is ours
  always_comb begin
    rdata_nxt = 8'h00;
    rvalid_nxt = reg_rd;
    for (int i = 0; i < NUM_TC; i++) begin
      if (reg_rd && sel_hit[i]) begin
        rdata_nxt = tc_r[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign reg_hit = |sel_hit;
  assign left_decay_eff = eff_r[CH_LDEC];
  assign right_attack_eff = eff_r[CH_RATK];
  assign right_decay_eff = eff_r[CH_RDEC];

  // ==========================================================================
  // assertions

  // a stored programmable setting lands in the output one edge later
  sequence s_ld_prog(logic [1:0] b, logic [2:0] m);
    tc_r[CH_LDEC].src_new && tc_r[CH_LDEC].base == b && tc_r[CH_LDEC].mult == m;
  endsequence

  sequence s_wr_then_hold(logic [6:0] a);
    reg_wr && reg_addr == a ##1 !reg_wr;
  endsequence

  a_reset_clears: assert property (@(posedge sys_clk) rst |=>
    tc_r[CH_LDEC] == 8'h00 && tc_r[CH_RATK] == 8'h00 && tc_r[CH_RDEC] == 8'h00)
    else $error("registers not cleared by reset");

  a_write_to_eff: assert property (@(posedge sys_clk) disable iff (rst)
    s_wr_then_hold(`AGTC_OFF_RIGHT_ATTACK) |=>
    right_attack_eff.src_new == $past(reg_wdata[`AGTC_BIT_SRC_SEL], 2))
    else $error("source flag did not follow the write two edges on");

  a_left_legacy_src: assert property (@(posedge sys_clk) disable iff (rst)
    !tc_r[CH_LDEC].src_new && legacy_left_decay_ms < `AGTC_CAP_R1_MS |=>
    left_decay_eff.ms == $past(legacy_left_decay_ms) && !left_decay_eff.src_new)
    else $error("left decay did not use the legacy time");

  a_left_base_dec: assert property (@(posedge sys_clk) disable iff (rst)
    s_ld_prog(2'h1, 3'h0) |=> left_decay_eff.ms == 16'd150)
    else $error("left decay baseline 01 is not 150 ms");

  a_decay_mult_dec: assert property (@(posedge sys_clk) disable iff (rst)
    s_ld_prog(2'h0, 3'h4) |=> left_decay_eff.ms == 16'd800)
    else $error("left decay factor 16 wrong");

  a_atk_mult_dec: assert property (@(posedge sys_clk) disable iff (rst)
    tc_r[CH_RATK].src_new && tc_r[CH_RATK].base == 2'h0 && tc_r[CH_RATK].mult == 3'h7
    |=> right_attack_eff.ms == 16'd896)
    else $error("right attack factor 128 wrong");

  a_ratk_legacy_src: assert property (@(posedge sys_clk) disable iff (rst)
    !tc_r[CH_RATK].src_new |=> right_attack_eff.ms == $past(legacy_right_attack_ms))
    else $error("right attack did not use the legacy time");

  a_atk_base_dec: assert property (@(posedge sys_clk) disable iff (rst)
    tc_r[CH_RATK].src_new && tc_r[CH_RATK].base == 2'h3 && tc_r[CH_RATK].mult == 3'h0
    |=> right_attack_eff.ms == 16'd11)
    else $error("right attack baseline 11 is not 11 ms");

  a_rdec_legacy_src: assert property (@(posedge sys_clk) disable iff (rst)
    !tc_r[CH_RDEC].src_new && legacy_right_decay_ms < `AGTC_CAP_R1_MS |=>
    right_decay_eff.ms == $past(legacy_right_decay_ms))
    else $error("right decay did not use the legacy time");

  a_rdec_base_dec: assert property (@(posedge sys_clk) disable iff (rst)
    tc_r[CH_RDEC].src_new && tc_r[CH_RDEC].base == 2'h3 && tc_r[CH_RDEC].mult == 3'h0
    |=> right_decay_eff.ms == 16'd350)
    else $error("right decay baseline 11 is not 350 ms");

  a_cap_low_ratio: assert property (@(posedge sys_clk) disable iff (rst)
    adc_decimation_ratio == 4'h2 && tc_r[CH_RDEC].src_new &&
    tc_r[CH_RDEC].base == 2'h3 && tc_r[CH_RDEC].mult == 3'h7
    |=> right_decay_eff.ms == 16'd4000)
    else $error("decay not capped at 4 s for ratio 1");

  a_cap_high_ratio: assert property (@(posedge sys_clk) disable iff (rst)
    adc_decimation_ratio == 4'hc && tc_r[CH_LDEC].src_new &&
    tc_r[CH_LDEC].base == 2'h3 && tc_r[CH_LDEC].mult == 3'h7
    |=> left_decay_eff.ms == 16'd22400)
    else $error("decay not capped at 22.4 s for ratio 6");

  a_read_back: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd && !reg_wr && reg_addr == `AGTC_OFF_RIGHT_DECAY |=>
    reg_rvalid && reg_rdata == $past(tc_r[CH_RDEC]))
    else $error("read data does not match the stored register");

  // left decay at its largest setting under a chosen ratio code
  sequence s_ld_max(logic [3:0] r);
    adc_decimation_ratio == r && tc_r[CH_LDEC].src_new &&
    tc_r[CH_LDEC].base == 2'h3 && tc_r[CH_LDEC].mult == 3'h7;
  endsequence

  a_cap_ratio_1p5: assert property (@(posedge sys_clk) disable iff (rst)
    s_ld_max(4'h3) |=> left_decay_eff.ms == 16'd5600)
    else $error("decay not capped at 5.6 s for ratio 1.5");

  a_cap_ratio_3p5: assert property (@(posedge sys_clk) disable iff (rst)
    s_ld_max(4'h7) |=> left_decay_eff.ms == 16'd11200)
    else $error("decay not capped at 11.2 s for ratio 3.5");

  a_cap_legacy_dec: assert property (@(posedge sys_clk) disable iff (rst)
    adc_decimation_ratio == 4'h2 && !tc_r[CH_RDEC].src_new &&
    legacy_right_decay_ms > `AGTC_CAP_R1_MS |=> right_decay_eff.ms == 16'd4000)
    else $error("legacy right decay not capped at 4 s for ratio 1");

  a_atk_no_cap: assert property (@(posedge sys_clk) disable iff (rst)
    adc_decimation_ratio == 4'h2 && tc_r[CH_RATK].src_new &&
    tc_r[CH_RATK].base == 2'h3 && tc_r[CH_RATK].mult == 3'h7
    |=> right_attack_eff.ms == 16'd1408)
    else $error("right attack was clipped by the decay ceiling");

  a_left_src_flag: assert property (@(posedge sys_clk) disable iff (rst)
    tc_r[CH_LDEC].src_new |=> left_decay_eff.src_new)
    else $error("left decay flag does not show the programmable source");

  a_read_strobe: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd |=> reg_rvalid)
    else $error("read strobe got no answer one edge later");

  a_read_idle: assert property (@(posedge sys_clk) disable iff (rst)
    !reg_rd |=> !reg_rvalid)
    else $error("read answer without a read strobe");

  a_read_unmapped: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd && !reg_hit |=> reg_rdata == 8'h00)
    else $error("unmapped read did not answer zero");

endmodule

`default_nettype wire

// ==== sim/tb_agtc_regs.sv ====
/*
  tb_agtc_regs.sv - self-checking bench for the agc time-constant bank.
  assumes: the bank's one-cycle strobe port, reads answered one edge later,
  effective times settled two edges after a write; inputs move on negedge.
*/
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// compare macro: counts every check, reports a mismatch at once
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_agtc_regs;
  // ========================================================================
  // signals
  logic sys_clk = 1'b0; // 250 MHz
  logic rst = 1'b1; // held high at start
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic reg_hit;
  logic [15:0] lg_ld = 16'h012c; // legacy left decay, 300 ms
  logic [15:0] lg_ra = 16'h0014; // legacy right attack, 20 ms
  logic [15:0] lg_rd = 16'h2328; // legacy right decay, 9000 ms
  logic [3:0] adc_decimation_ratio = 4'hc; // ratio 6
  agtc_pkg::agtc_eff_t left_decay_eff;
  agtc_pkg::agtc_eff_t right_attack_eff;
  agtc_pkg::agtc_eff_t right_decay_eff;
  int bad_count = 0;
  int cmp_count = 0;
  logic [7:0] d;

  agtc_regs agtc_regs_inst (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_hit(reg_hit), .legacy_left_decay_ms(lg_ld),
    .legacy_right_attack_ms(lg_ra), .legacy_right_decay_ms(lg_rd),
    .adc_decimation_ratio(adc_decimation_ratio), .left_decay_eff(left_decay_eff),
    .right_attack_eff(right_attack_eff), .right_decay_eff(right_decay_eff));

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  // ========================================================================
  // expected-value helpers, worked out independently of the design
  function automatic int cap(input int r); // decay ceiling by twice the ratio
    case (r)
      3: return 5600;
      4: return 8000;
      5: return 9600;
      6, 7: return 11200;
      8, 9: return 16000;
      10: return 19200;
      11, 12: return 22400;
      default: return 4000; // ratio 1 and the unused codes
    endcase
  endfunction
  function automatic int lim(input int v, input int r); // clip to ceiling
    return (v > cap(r)) ? cap(r) : v;
  endfunction
  function automatic int atk(input int c); // attack baseline in ms
    case (c)
      0: return 7;
      1: return 8;
      2: return 10;
      default: return 11;
    endcase
  endfunction
  function automatic agtc_pkg::agtc_eff_t mk(input logic s, input int ms);
    return {s, 16'(ms)};
  endfunction

  // ========================================================================
  // bus tasks
  task automatic final_report;
    $display("comparisons=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    int n;
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 4) begin
      bad_count++;
      final_report();
    end else begin
      `CHK(reg_rdata, e)
    end
  endtask
  task automatic wr_all(input logic [7:0] v); // same byte to all three
    wr(7'h68, v);
    wr(7'h69, v);
    wr(7'h6a, v);
    repeat (3) @(negedge sys_clk); // two-edge update latency plus margin
  endtask

  // ========================================================================
  // hang guard: a stuck run still reaches the verdict
  initial begin
    #200000;
    bad_count++;
    final_report();
  end

  // ========================================================================
  // main sequence
  initial begin
    repeat (16) @(posedge sys_clk); // sixteen edges in reset
    @(negedge sys_clk);
    rst = 1'b0;
    // reset state: zeros, legacy sources in use
    rd_chk(7'h68, 8'h00);
    rd_chk(7'h69, 8'h00);
    rd_chk(7'h6a, 8'h00);
    `CHK(left_decay_eff, mk(1'b0, 300))
    `CHK(right_attack_eff, mk(1'b0, 20))
    `CHK(right_decay_eff, mk(1'b0, 9000))
    // every baseline and factor code
    for (int b = 0; b < 4; b++) begin
      for (int m = 0; m < 8; m++) begin
        d = {1'b1, 2'(b), 3'(m), 2'b00}; // reserved bits written as zero
        wr_all(d);
        `CHK(left_decay_eff, mk(1'b1, lim((50 + 100 * b) << m, 12)))
        `CHK(right_attack_eff, mk(1'b1, atk(b) << m))
        `CHK(right_decay_eff, mk(1'b1, lim((50 + 100 * b) << m, 12)))
        rd_chk(7'h69, d);
      end
    end
    // ceilings across every ratio code, attack never clipped
    for (int r = 0; r < 16; r++) begin
      adc_decimation_ratio = 4'(r);
      repeat (2) @(negedge sys_clk);
      `CHK(left_decay_eff, mk(1'b1, lim(44800, r)))
      `CHK(right_decay_eff, mk(1'b1, lim(44800, r)))
      `CHK(right_attack_eff, mk(1'b1, 1408))
    end
    // source bit cleared: new fields ignored, legacy tracked
    adc_decimation_ratio = 4'hc;
    wr_all(8'h7c);
    `CHK(left_decay_eff, mk(1'b0, 300))
    `CHK(right_attack_eff, mk(1'b0, 20))
    `CHK(right_decay_eff, mk(1'b0, 9000))
    // tight ceiling clips the legacy decay too, legacy attack passes
    adc_decimation_ratio = 4'h2;
    lg_ra = 16'h0190; // legacy right attack, 400 ms
    repeat (2) @(negedge sys_clk);
    `CHK(right_decay_eff, mk(1'b0, lim(9000, 2)))
    `CHK(left_decay_eff, mk(1'b0, 300))
    `CHK(right_attack_eff, mk(1'b0, 400))
    adc_decimation_ratio = 4'hc;
    // unmapped places: ignored write, zero read, no hit
    wr(7'h67, 8'hff);
    rd_chk(7'h68, 8'h7c);
    rd_chk(7'h6b, 8'h00);
    `CHK(reg_hit, 1'b0)
    // reset in mid-run clears all fields again
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    rd_chk(7'h6a, 8'h00);
    `CHK(reg_hit, 1'b1)
    `CHK(right_decay_eff, mk(1'b0, 9000))
    final_report();
  end
endmodule

`default_nettype wire
